// ==== hdl/mcv_pkg.sv ====
// constants and carriers for the machine check syndrome and vectoring unit
// assumes a single core clock and special-register access by number
//
// How it works
// - taking a machine check clears the recoverable flag; otherwise software owns it
// - marked-process bit plus user flag form a state; counting when it matches
// - unimplemented state and vector base bits read zero, writes dropped
// - syndrome resets to zero and hardware never clears a set bit
// - check output pin is high while any async or error-report bit is set
// - writing one clears a syndrome bit, writing zero leaves it
// - any set async syndrome bit raises a machine check when enabled
// - async bits set on detection; interrupt when enabled, else stays pending
// - error-report bits update only when taken; not masked by check enable
// - non-maskable bit set only when taken; not gated by check enable
// - bits 0 to 6 hold pin, cache parity and first-fetch causes in order
// - bits 27, 28, 29 hold fetch read, data read and write bus errors
// - bits 7 and 8 flag instruction and data cache lock errors
// - bit 12 set on first async address capture; bit 13 marks effective address
// - bits 15, 16, 17 flag fetch, load, store failures; pc saved
// - bit 18 flags a guarded access external bus error
// - vector base holds 16 bits giving upper handler address, 64 KB aligned
// - handler address is stored base joined with selected offset field
// - offset field is a quadword index: base, offset, four zero bits
`default_nettype none

package mcv_pkg;
  // special register numbers
  localparam logic [9:0] REG_VECTOR_BASE = 10'h03f;
  localparam logic [9:0] REG_SYNDROME = 10'h23c;
  // machine state bit positions (lsb numbering)
  localparam int MS_DS = 4;
  localparam int MS_IS = 5;
  localparam int MS_MARK = 2;
  localparam int MS_RECOV = 1;
  localparam int MS_DE = 9;
  localparam int MS_FE1 = 8;
  localparam int MS_FE0 = 11;
  localparam int MS_MCE = 12;
  localparam int MS_FP = 13;
  localparam int MS_USER = 14;
  localparam int MS_EE = 15;
  localparam int MS_CE = 17;
  localparam int MS_WE = 18;
  localparam int MS_VEC_AVAIL = 25;
  localparam int MS_UCLE = 26;
  // implemented machine state bits
  localparam logic [31:0] MS_IMPL_MASK = 32'h0606_fb36;
  localparam logic [31:0] MS_RESET = 32'h0000_0000;
  // syndrome bit positions (lsb numbering: msb bit n is 31-n)
  localparam int SY_PIN = 31;
  localparam int SY_IC_DPAR = 30;
  localparam int SY_PUSH_PAR = 29;
  localparam int SY_DC_DPAR = 28;
  localparam int SY_FIRST_FETCH = 27;
  localparam int SY_IC_TPAR = 26;
  localparam int SY_DC_TPAR = 25;
  localparam int SY_IC_LOCK = 24;
  localparam int SY_DC_LOCK = 23;
  localparam int SY_NMI = 20;
  localparam int SY_CAPT_VALID = 19;
  localparam int SY_CAPT_EFF = 18;
  localparam int SY_FETCH_REP = 16;
  localparam int SY_LOAD_REP = 15;
  localparam int SY_STORE_REP = 14;
  localparam int SY_GUARD_REP = 13;
  localparam int SY_PROBE = 5;
  localparam int SY_BUS_FETCH = 4;
  localparam int SY_BUS_DREAD = 3;
  localparam int SY_BUS_WRITE = 2;
  // syndrome classes
  localparam logic [31:0] SY_ASYNC_MASK = 32'hfe00_003c;
  localparam logic [31:0] SY_REPORT_MASK = 32'h0001_e000;
  localparam logic [31:0] SY_NMI_MASK = 32'h0010_0000;
  localparam logic [31:0] SY_STATUS_MASK = 32'h018c_0000;
  localparam logic [31:0] SY_RESET = 32'h0000_0000;
  // vector base and offset
  localparam int VB_WIDTH = 16;
  localparam int VO_WIDTH = 12;
  localparam int VO_PAD = 4;
  localparam logic [31:0] VB_MASK = 32'hffff_0000;
  localparam logic [VO_PAD-1:0] VO_ZERO = 4'h0;

  // async detection group
  typedef struct packed {
    logic pin;
    logic ic_data_par;
    logic push_par;
    logic dc_data_par;
    logic first_fetch;
    logic ic_tag_par;
    logic dc_tag_par;
    logic probe;
    logic bus_fetch;
    logic bus_dread;
    logic bus_write;
  } mcv_async_t;

  // error report group presented by the oldest instruction
  typedef struct packed {
    logic fetch;
    logic load;
    logic store;
    logic guarded;
  } mcv_report_t;

  // special register access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] num;
    logic [31:0] wdata;
  } mcv_reg_req_t;
endpackage : mcv_pkg

`default_nettype wire

// ==== hdl/mcv_syndrome.sv ====
// syndrome register with write-one-to-clear and hardware set priority
// assumes set and clear vectors arrive in the core clock domain
`default_nettype none

module mcv_syndrome (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // update
  input wire logic [31:0] hw_set,
  input wire logic [31:0] sw_clear,
  // state
  output logic [31:0] value
);
  typedef struct packed {
    logic [31:0] bits;
  } mcv_sy_state_t;

  mcv_sy_state_t st;
  mcv_sy_state_t next_st;

  // set wins over clear; no hardware clear
  always_comb begin
    next_st = st;
    next_st.bits = (st.bits & ~sw_clear) | hw_set;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st.bits <= mcv_pkg::SY_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign value = st.bits;

  a_set_wins: assert property (@(posedge core_clk) disable iff (!resetn)
    (hw_set != 32'h0) |=> ((value & $past(hw_set)) == $past(hw_set)))
    else $error("hardware set lost");
  a_no_hw_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    ((~value & $past(value)) & ~$past(sw_clear)) == 32'h0)
    else $error("syndrome bit cleared without write");
endmodule : mcv_syndrome

`default_nettype wire

// ==== hdl/mcv_vector.sv ====
// handler address formation from base and offset
// assumes the offset is already selected for the interrupt type
`default_nettype none

module mcv_vector (
  // inputs
  input wire logic [mcv_pkg::VB_WIDTH-1:0] base,
  input wire logic [mcv_pkg::VO_WIDTH-1:0] offset,
  // result
  output logic [31:0] addr
);
  // base, quadword index, zero pad
  assign addr = {base, offset, mcv_pkg::VO_ZERO};
endmodule : mcv_vector

`default_nettype wire

// ==== hdl/mcv_unit.sv ====
// machine check syndrome logging, machine state tail and vector base
// assumes the pipeline asks for interrupts and accesses registers by number
`default_nettype none

module mcv_unit (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register access
  input wire mcv_pkg::mcv_reg_req_t reg_req,
  input wire logic ms_wr,
  input wire logic [31:0] ms_wdata,
  // error sources
  input wire mcv_pkg::mcv_async_t async_err,
  input wire logic icache_lock_error,
  input wire logic dcache_lock_error,
  input wire logic capture_load,
  input wire logic capture_is_eff,
  input wire logic [31:0] capture_addr,
  input wire mcv_pkg::mcv_report_t report_err,
  input wire logic [31:0] report_pc,
  input wire logic nmi_req,
  // interrupt sequencing
  input wire logic other_irq_take,
  input wire logic [mcv_pkg::VO_WIDTH-1:0] other_offset,
  input wire logic [mcv_pkg::VO_WIDTH-1:0] check_offset,
  input wire logic [1:0] perf_state_sel,
  // outputs
  output logic [31:0] reg_rdata,
  output logic [31:0] machine_state,
  output logic machine_check_out,
  output logic check_take,
  output logic [31:0] handler_addr,
  output logic [31:0] check_address_capture,
  output logic [31:0] check_saved_pc,
  output logic perf_count_enable
);
  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [31:0] ms;
    logic [mcv_pkg::VB_WIDTH-1:0] vbase;
    logic [31:0] rdata;
    logic mc_out;
    logic take;
    logic [31:0] haddr;
    logic [31:0] capt;
    logic [31:0] spc;
    logic perf_en;
  } mcv_state_t;

  mcv_state_t st;
  mcv_state_t next_st;
  logic [31:0] syn;
  logic [31:0] hw_set;
  logic [31:0] sw_clear;
  logic [31:0] vec_addr;
  logic [mcv_pkg::VO_WIDTH-1:0] sel_offset;
  logic async_pend;
  logic report_pend;
  logic take_now;
  logic first_capture;

  // register number decode used for reads and writes
  function automatic logic hits(input logic [9:0] n, input logic [9:0] r);
    hits = (n == r);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pending conditions and take decision
  always_comb begin
    async_pend = ((syn & mcv_pkg::SY_ASYNC_MASK) != 32'h0) ||
                 (async_err != '0);
    report_pend = (report_err != '0);
    // error report and nmi ignore enable; async needs it
    take_now = report_pend || nmi_req ||
               (async_pend && st.ms[mcv_pkg::MS_MCE]);
    first_capture = capture_load && !syn[mcv_pkg::SY_CAPT_VALID];
    sel_offset = take_now ? check_offset : other_offset;
  end

  ////////////////////////////////////////////////////////////////////////
  // hardware set vector
  always_comb begin
    hw_set = 32'h0;
    // async set on detection
    hw_set[mcv_pkg::SY_PIN] = async_err.pin;
    hw_set[mcv_pkg::SY_IC_DPAR] = async_err.ic_data_par;
    hw_set[mcv_pkg::SY_PUSH_PAR] = async_err.push_par;
    hw_set[mcv_pkg::SY_DC_DPAR] = async_err.dc_data_par;
    hw_set[mcv_pkg::SY_FIRST_FETCH] = async_err.first_fetch;
    hw_set[mcv_pkg::SY_IC_TPAR] = async_err.ic_tag_par;
    hw_set[mcv_pkg::SY_DC_TPAR] = async_err.dc_tag_par;
    hw_set[mcv_pkg::SY_PROBE] = async_err.probe;
    hw_set[mcv_pkg::SY_BUS_FETCH] = async_err.bus_fetch;
    hw_set[mcv_pkg::SY_BUS_DREAD] = async_err.bus_dread;
    hw_set[mcv_pkg::SY_BUS_WRITE] = async_err.bus_write;
    // status bits
    hw_set[mcv_pkg::SY_IC_LOCK] = icache_lock_error;
    hw_set[mcv_pkg::SY_DC_LOCK] = dcache_lock_error;
    hw_set[mcv_pkg::SY_CAPT_VALID] = first_capture;
    hw_set[mcv_pkg::SY_CAPT_EFF] = first_capture && capture_is_eff;
    // report and nmi only when actually taken
    hw_set[mcv_pkg::SY_FETCH_REP] = take_now && report_err.fetch;
    hw_set[mcv_pkg::SY_LOAD_REP] = take_now && report_err.load;
    hw_set[mcv_pkg::SY_STORE_REP] = take_now && report_err.store;
    hw_set[mcv_pkg::SY_GUARD_REP] = take_now && report_err.guarded;
    hw_set[mcv_pkg::SY_NMI] = take_now && nmi_req;
  end

  // software write-one-to-clear
  always_comb begin
    sw_clear = 32'h0;
    if (reg_req.wr && hits(reg_req.num, mcv_pkg::REG_SYNDROME)) begin
      sw_clear = reg_req.wdata;
    end
  end

  mcv_syndrome u_syn (
    .core_clk(core_clk),
    .resetn(resetn),
    .hw_set(hw_set),
    .sw_clear(sw_clear),
    .value(syn)
  );

  mcv_vector u_vec (
    .base(st.vbase),
    .offset(sel_offset),
    .addr(vec_addr)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    next_st.take = take_now || other_irq_take;
    if (take_now || other_irq_take) begin
      next_st.haddr = vec_addr;
    end
    // software writes, unimplemented bits dropped
    if (ms_wr) begin
      next_st.ms = ms_wdata & mcv_pkg::MS_IMPL_MASK;
    end
    if (take_now) begin
      next_st.ms[mcv_pkg::MS_RECOV] = 1'b0;
    end
    if (reg_req.wr && hits(reg_req.num, mcv_pkg::REG_VECTOR_BASE)) begin
      next_st.vbase = reg_req.wdata[31:32-mcv_pkg::VB_WIDTH];
    end
    if (first_capture) begin
      next_st.capt = capture_addr;
    end
    if (take_now && report_pend) begin
      next_st.spc = report_pc;
    end
    // read mux
    next_st.rdata = 32'h0;
    if (reg_req.rd && hits(reg_req.num, mcv_pkg::REG_SYNDROME)) begin
      next_st.rdata = syn;
    end else if (reg_req.rd &&
                 hits(reg_req.num, mcv_pkg::REG_VECTOR_BASE)) begin
      next_st.rdata = {st.vbase, 16'h0000};
    end
    // pin follows the next syndrome value
    next_st.mc_out = (((syn & ~sw_clear) | hw_set) &
                      (mcv_pkg::SY_ASYNC_MASK |
                       mcv_pkg::SY_REPORT_MASK)) != 32'h0;
    next_st.perf_en = ({next_st.ms[mcv_pkg::MS_USER],
                        next_st.ms[mcv_pkg::MS_MARK]} ==
                       perf_state_sel);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata = st.rdata;
  assign machine_state = st.ms;
  assign machine_check_out = st.mc_out;
  assign check_take = st.take;
  assign handler_addr = st.haddr;
  assign check_address_capture = st.capt;
  assign check_saved_pc = st.spc;
  assign perf_count_enable = st.perf_en;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_ri_cleared: assert property (@(posedge core_clk) disable iff (!resetn)
    take_now |=> !machine_state[mcv_pkg::MS_RECOV])
    else $error("recoverable flag kept on take");
  a_ms_unimpl: assert property (@(posedge core_clk) disable iff (!resetn)
    (machine_state & ~mcv_pkg::MS_IMPL_MASK) == 32'h0)
    else $error("unimplemented state bit set");
  a_pin_follows: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 (machine_check_out == ((syn & (mcv_pkg::SY_ASYNC_MASK |
    mcv_pkg::SY_REPORT_MASK)) != 32'h0)))
    else $error("check pin mismatch");
  a_async_gated: assert property (@(posedge core_clk) disable iff (!resetn)
    ((syn & mcv_pkg::SY_ASYNC_MASK) != 32'h0 &&
     machine_state[mcv_pkg::MS_MCE])
    |=> check_take)
    else $error("pending async not taken");
  a_masked_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    (!machine_state[mcv_pkg::MS_MCE] && !report_pend && !nmi_req &&
     !other_irq_take) |=> !check_take)
    else $error("masked async taken");
  a_report_take: assert property (@(posedge core_clk) disable iff (!resetn)
    report_err.load |=> (check_take && syn[mcv_pkg::SY_LOAD_REP] &&
    check_saved_pc == $past(report_pc)))
    else $error("load report not logged");
  a_nmi_take: assert property (@(posedge core_clk) disable iff (!resetn)
    nmi_req |=> (check_take && syn[mcv_pkg::SY_NMI]))
    else $error("nmi not logged");
  a_vec_form: assert property (@(posedge core_clk) disable iff (!resetn)
    take_now |=> (handler_addr[3:0] == 4'h0 &&
    handler_addr[15:4] == $past(check_offset)))
    else $error("bad handler address");
  a_base_read: assert property (@(posedge core_clk) disable iff (!resetn)
    (reg_req.rd && reg_req.num == mcv_pkg::REG_VECTOR_BASE) |=>
    (reg_rdata[15:0] == 16'h0))
    else $error("base low bits not zero");
endmodule : mcv_unit

`default_nettype wire

// ==== tb/mcv_unit_tb.sv ====
// self-checking bench for the machine check syndrome and vectoring unit
// assumes mcv_pkg and mcv_unit are compiled first; one 100 MHz clock
`default_nettype none

module mcv_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  mcv_pkg::mcv_reg_req_t req = '0;
  logic ms_wr = 1'b0;
  logic [31:0] ms_wdata = 32'h0;
  mcv_pkg::mcv_async_t aerr = '0;
  logic ilk = 1'b0;
  logic dlk = 1'b0;
  logic cap_load = 1'b0;
  logic cap_eff = 1'b0;
  logic [31:0] cap_addr = 32'h0;
  mcv_pkg::mcv_report_t rep = '0;
  logic [31:0] rep_pc = 32'h0;
  logic nmi = 1'b0;
  logic oth = 1'b0;
  logic [11:0] oth_off = 12'h0;
  logic [11:0] chk_off = 12'h0;
  logic [1:0] psel = 2'h0;
  logic [31:0] rdata, mstate, cap_out, pc_out, haddr;
  logic mco, take, pce, rd_d;
  logic [31:0] exp_q[$];
  logic [15:0] vb;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 32'h4c32aa72;
  int apos[11] = '{31, 30, 29, 28, 27, 26, 25, 5, 4, 3, 2};
  int rpos[4] = '{16, 15, 14, 13};

  mcv_unit DUT (.core_clk(core_clk), .resetn(resetn), .reg_req(req),
    .ms_wr(ms_wr), .ms_wdata(ms_wdata), .async_err(aerr),
    .icache_lock_error(ilk), .dcache_lock_error(dlk),
    .capture_load(cap_load), .capture_is_eff(cap_eff),
    .capture_addr(cap_addr), .report_err(rep), .report_pc(rep_pc),
    .nmi_req(nmi), .other_irq_take(oth), .other_offset(oth_off),
    .check_offset(chk_off), .perf_state_sel(psel), .reg_rdata(rdata),
    .machine_state(mstate), .machine_check_out(mco), .check_take(take),
    .handler_addr(haddr), .check_address_capture(cap_out),
    .check_saved_pc(pc_out), .perf_count_enable(pce));

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // read data watcher: one cycle after each read, oldest note first
  always @(posedge core_clk) begin
    if (rd_d) begin
      if (exp_q.size() == 0)
        chk(rdata, 32'hx, "read without note");
      else
        chk(rdata, exp_q.pop_front(), "read data");
    end
    rd_d <= resetn && req.rd;
  end

  ////////////////////////////////////////////////////////////////////////
  // bus tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [9:0] num, input logic [31:0] d);
    @(posedge core_clk);
    req.wr <= 1'b1;
    req.num <= num;
    req.wdata <= d;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] num, input logic [31:0] e);
    @(posedge core_clk);
    req.rd <= 1'b1;
    req.num <= num;
    exp_q.push_back(e);
    @(posedge core_clk);
    req.rd <= 1'b0;
  endtask
  task automatic msw(input logic [31:0] d);
    @(posedge core_clk);
    ms_wr <= 1'b1;
    ms_wdata <= d;
    @(posedge core_clk);
    ms_wr <= 1'b0;
  endtask
  // looks for a take pulse over n cycles
  task automatic tk(input logic e, input int n, input string msg);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (take === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, e}, msg);
  endtask
  task automatic clr();
    wr(mcv_pkg::REG_SYNDROME, 32'hffff_ffff);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    vb = 16'($random(seed));
    chk_off = 12'($random(seed));
    cyc(8);
    resetn <= 1'b1;
    rd(mcv_pkg::REG_SYNDROME, 32'h0);
    #1 chk(mstate, 32'h0, "state reset");
    wr(mcv_pkg::REG_VECTOR_BASE, {vb, 16'($random(seed))});
    rd(mcv_pkg::REG_VECTOR_BASE, {vb, 16'h0});
    rd(10'h100, 32'h0);
    msw(32'hffff_ffff);
    #1 chk(mstate, mcv_pkg::MS_IMPL_MASK, "state mask");
    msw(32'h0);
    $display("test registers done");
    for (int i = 0; i < 11; i++) begin
      clr();
      @(posedge core_clk);
      aerr <= mcv_pkg::mcv_async_t'(11'h1 << (10 - i));
      @(posedge core_clk);
      aerr <= '0;
      cyc(2);
      #1 chk({31'h0, mco}, 32'h1, "pin out");
      tk(1'b0, 4, "masked take");
      rd(mcv_pkg::REG_SYNDROME, 32'h1 << apos[i]);
      msw((32'h1 << mcv_pkg::MS_MCE) | (32'h1 << mcv_pkg::MS_RECOV));
      tk(1'b1, 4, "pending take");
      chk({31'h0, mstate[mcv_pkg::MS_RECOV]}, 32'h0, "recov flag");
      chk(haddr, {vb, chk_off, 4'h0}, "vector");
      msw(32'h0);
    end
    $display("test async done");
    // zero write, same-cycle set and clear, then clear
    wr(mcv_pkg::REG_SYNDROME, 32'h0);
    rd(mcv_pkg::REG_SYNDROME, 32'h4);
    @(posedge core_clk);
    aerr.pin <= 1'b1;
    req.wr <= 1'b1;
    req.num <= mcv_pkg::REG_SYNDROME;
    req.wdata <= 32'h8000_0004;
    @(posedge core_clk);
    aerr.pin <= 1'b0;
    req.wr <= 1'b0;
    cyc(10);
    rd(mcv_pkg::REG_SYNDROME, 32'h8000_0000);
    clr();
    rd(mcv_pkg::REG_SYNDROME, 32'h0);
    $display("test clear done");
    msw(32'h1 << mcv_pkg::MS_MCE);
    @(posedge core_clk);
    ilk <= 1'b1;
    dlk <= 1'b1;
    @(posedge core_clk);
    ilk <= 1'b0;
    dlk <= 1'b0;
    tk(1'b0, 4, "status take");
    chk({31'h0, mco}, 32'h0, "status pin");
    rd(mcv_pkg::REG_SYNDROME, 32'h0180_0000);
    msw(32'h0);
    for (int e = 0; e < 2; e++) begin
      clr();
      @(posedge core_clk);
      cap_load <= 1'b1;
      cap_eff <= e[0];
      cap_addr <= $random(seed);
      @(posedge core_clk);
      cap_load <= 1'b0;
      rd(mcv_pkg::REG_SYNDROME, e ? 32'h000c_0000 : 32'h0008_0000);
      chk(cap_out, cap_addr, "capture");
    end
    $display("test status done");
    for (int j = 0; j < 4; j++) begin
      clr();
      @(posedge core_clk);
      rep_pc <= $random(seed);
      rep <= mcv_pkg::mcv_report_t'(4'h1 << (3 - j));
      tk(1'b1, 4, "report take");
      @(posedge core_clk);
      rep <= '0;
      rd(mcv_pkg::REG_SYNDROME, 32'h1 << rpos[j]);
      chk(pc_out, rep_pc, "saved pc");
      chk({31'h0, mco}, 32'h1, "report pin");
    end
    clr();
    @(posedge core_clk);
    nmi <= 1'b1;
    tk(1'b1, 4, "nmi take");
    @(posedge core_clk);
    nmi <= 1'b0;
    rd(mcv_pkg::REG_SYNDROME, 32'h0010_0000);
    clr();
    @(posedge core_clk);
    oth <= 1'b1;
    oth_off <= 12'($random(seed));
    @(posedge core_clk);
    oth <= 1'b0;
    cyc(2);
    chk(haddr, {vb, oth_off, 4'h0}, "other vector");
    $display("test report done");
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 4; s++) begin
        psel <= 2'(s);
        msw((32'(k[1]) << mcv_pkg::MS_USER) |
            (32'(k[0]) << mcv_pkg::MS_MARK));
        cyc(2);
        chk({31'h0, pce}, {31'h0, s == k}, "perf");
      end
    end
    $display("test perf done");
    cyc(3);
    end_of_test();
  end
endmodule // mcv_unit_tb

`default_nettype wire
